// >>> adc_trig_map.svh
/*
 * Register offsets, field positions, reset values and trigger source codes
 * of the scan trigger selection block.
 * Assumes byte addresses on a 32-bit Avalon-MM slave port.
 */
`ifndef ADC_TRIG_MAP_SVH
`define ADC_TRIG_MAP_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define OFS_CONTROL_ONE 8'h00
`define OFS_TRIG_SEVEN 8'h04
`define OFS_SCAN_SELECT 8'h08
`define OFS_SW_TRIGGER 8'h0c
`define OFS_STATUS 8'h10

// ***************************************************************
// Field positions
// ***************************************************************
`define CTL_STRG_LSB 16
`define CTL_STRG_MSB 20
`define CTL_ON_BIT 15
`define CTL_IDLE_BIT 13
`define SCAN_HI_MSB 21
`define SCAN_LO_LSB 24
`define SCAN_LO_MSB 27
`define SW_EDGE_BIT 0
`define SW_LEVEL_BIT 1
`define STAT_RUN_BIT 8

// ***************************************************************
// Writable masks and reset values
// ***************************************************************
`define MASK_CONTROL_ONE 32'h001fa000
`define MASK_TRIG_SEVEN 32'h1f1f1f1f
`define MASK_SCAN_SELECT 32'h0f3fffff
`define RST_CONTROL_ONE 32'h00000000
`define RST_TRIG_SEVEN 32'h00000000
`define RST_SCAN_SELECT 32'h00000000

// ***************************************************************
// Trigger source codes
// ***************************************************************
`define CODE_NONE 5'h00
`define CODE_SW_EDGE 5'h01
`define CODE_SW_LEVEL 5'h02
`define CODE_SCAN 5'h03
`define CODE_INT0 5'h04
`define CODE_TMR1 5'h05
`define CODE_PWM_TB_PRI 5'h08
`define CODE_PWM_TRIG1 5'h0a
`define CODE_OC1 5'h10
`define CODE_CHARGE_TRIP 5'h14
`define CODE_ILIM1 5'h18

`endif

// >>> adc_trig_pkg.sv
/*
 * Types shared by the scan trigger selection block.
 * Assumes the map header supplies the numeric constants.
 */
package adc_trig_pkg;

   typedef logic [4:0] trig_code_t;

   typedef struct packed {
      trig_code_t scan_trigger_select;
      logic on;
      logic idle_stop;
      logic [31:0] trig_seven;
      logic [31:0] scan_input_select;
      logic sw_edge;
      logic sw_level;
      logic [7:0] launch_count;
      logic wait_req;
      logic [31:0] rdata;
      logic run;
      logic [21:0] scan_out;
   } ctl_t;

   typedef struct packed {
      logic prev;
      logic hit;
   } mux_state_t;

endpackage

// >>> trig_src_if.sv
/*
 * Carrier of the shared trigger source vector and run level.
 * Assumes one driver (the top) and any number of selector readers.
 */
`timescale 1ns/1ps
interface trig_src_if;
   logic [31:0] src;
   logic run;
   modport drv (output src, output run);
   modport sel (input src, input run);
endinterface

// >>> trig_source_mux.sv
/*
 * One trigger selector: picks a source by its 5-bit code and launches on
 * the rising edge, or on every cycle of a held level for the level code.
 * Assumes all sources are synchronous to i_mclk.
 */
`timescale 1ns/1ps
`include "adc_trig_map.svh"
module trig_source_mux (
   input wire logic i_mclk,                        // System clock.
   input wire logic i_rst_n,                       // Async reset, low.
   trig_src_if.sel bus,                            // Shared sources.
   input wire adc_trig_pkg::trig_code_t i_code,    // Source select code.
   input wire logic i_scan_in,                     // Source for scan code.
   output logic o_hit                              // Launch pulse.
);
   import adc_trig_pkg::*;

   mux_state_t st_r;
   mux_state_t st_nxt;
   logic [31:0] vec;
   logic sel;

   // ***************************************************************
   // Selection and launch
   // ***************************************************************
   always_comb begin
      vec = bus.src;
      vec[`CODE_SCAN] = i_scan_in;
      // Unlisted codes index bits that are held at zero.
      sel = vec[i_code];
      st_nxt.prev = sel;
      if (!bus.run) begin
         st_nxt.hit = 1'b0;
      end else if (i_code == `CODE_SW_LEVEL) begin
         st_nxt.hit = sel;
      end else begin
         st_nxt.hit = sel & ~st_r.prev;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_hit = st_r.hit;
endmodule

// >>> adc_scan_trigger_select.sv
/*
 * Scan trigger selection and converter enable control, with an Avalon-MM
 * register slave.
 * Assumes every trigger source comes from on-chip logic on i_mclk and that
 * the idle indication is synchronous as well.
 */
// Functional notes
// - Five-bit scan selector; zero launches nothing.
// - Code one software edge, two software level.
// - Code three selects the dedicated scan trigger.
// - Codes four to seven: interrupt zero, timers.
// - Codes eight, nine: primary, secondary PWM time base.
// - Codes ten to fifteen: PWM generator triggers.
// - Compare period ends, then charge-time trip code.
// - Codes twenty-four to twenty-nine: PWM current-limit events.
// - Scan selection governs inputs 32 to 53 and marks inputs 24 to 27.
// - Bit fifteen enables module; reset disabled.
// - Bit thirteen stops module during idle mode.
// - Inputs 24-27 selectors share the encoding, but their code three takes the scan launch when the input is marked.
`timescale 1ns/1ps
`include "adc_trig_map.svh"
module adc_scan_trigger_select (
   input wire logic i_mclk,                  // System clock, 250 MHz.
   input wire logic i_rst_n,                 // Async reset, active low.
   input wire logic [7:0] i_address,         // Avalon byte address.
   input wire logic i_read,                  // Avalon read request.
   input wire logic i_write,                 // Avalon write request.
   input wire logic [3:0] i_byteenable,      // Avalon byte lanes.
   input wire logic [31:0] i_writedata,      // Avalon write data.
   output logic [31:0] o_readdata,           // Avalon read data.
   output logic o_waitrequest,               // Avalon wait request.
   input wire logic i_idle,                  // Device in idle mode.
   input wire logic i_scan_trig,             // Dedicated scan trigger.
   input wire logic i_ext_int0,              // External interrupt 0.
   input wire logic [2:0] i_timer_evt,       // Timers 1, 3, 5.
   input wire logic [1:0] i_pwm_tb,          // Primary, secondary base.
   input wire logic [5:0] i_pwm_trig,        // PWM generator 1..6.
   input wire logic [3:0] i_oc_end,          // Compare 1..4 period end.
   input wire logic i_charge_trip,           // Charge-time unit trip.
   input wire logic [5:0] i_pwm_ilim,        // PWM current limit 1..6.
   output logic o_scan_start,                // Scan launch pulse.
   output logic [21:0] o_scan_inputs,        // Scanned inputs 32..53.
   output logic [3:0] o_input_start,         // Launch of inputs 24..27.
   output logic o_adc_on,                    // Module enabled.
   output logic o_adc_run                    // Module running.
);
   import adc_trig_pkg::*;

   localparam int N_INPUTS = 4;

   ctl_t ctl_r;
   ctl_t ctl_nxt;
   logic scan_hit;
   logic [N_INPUTS-1:0] input_hit;
   logic [N_INPUTS-1:0] input_scan;
   logic accept;
   logic [31:0] bmask;
   logic [31:0] ctl_word;
   logic [31:0] sw_word;
   logic [31:0] stat_word;

   trig_src_if src_bus ();

   // ***************************************************************
   // Trigger source vector
   // ***************************************************************
   always_comb begin
      src_bus.src = 32'h0000_0000;
      src_bus.src[`CODE_SW_EDGE] = ctl_r.sw_edge;
      src_bus.src[`CODE_SW_LEVEL] = ctl_r.sw_level;
      src_bus.src[`CODE_INT0] = i_ext_int0;
      src_bus.src[`CODE_TMR1 +: 3] = i_timer_evt;
      src_bus.src[`CODE_PWM_TB_PRI +: 2] = i_pwm_tb;
      src_bus.src[`CODE_PWM_TRIG1 +: 6] = i_pwm_trig;
      src_bus.src[`CODE_OC1 +: 4] = i_oc_end;
      src_bus.src[`CODE_CHARGE_TRIP] = i_charge_trip;
      src_bus.src[`CODE_ILIM1 +: 6] = i_pwm_ilim;
      src_bus.run = ctl_r.run;
   end

   // ***************************************************************
   // Selectors
   // ***************************************************************
   trig_source_mux u_scan_mux (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .bus(src_bus),
      .i_code(ctl_r.scan_trigger_select),
      .i_scan_in(i_scan_trig),
      .o_hit(scan_hit)
   );

   // A per-input scan code only fires when the input is also marked for
   // the scan; otherwise the launch would reach an input nobody scans.
   genvar gi;
   generate
      for (gi = 0; gi < N_INPUTS; gi++) begin : g_input
         assign input_scan[gi] =
            scan_hit & ctl_r.scan_input_select[`SCAN_LO_LSB + gi];
         trig_source_mux u_in_mux (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .bus(src_bus),
            .i_code(ctl_r.trig_seven[gi*8 +: 5]),
            .i_scan_in(input_scan[gi]),
            .o_hit(input_hit[gi])
         );
      end
   endgenerate

   // ***************************************************************
   // Register views
   // ***************************************************************
   always_comb begin
      bmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
               {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
      ctl_word = 32'h0000_0000;
      ctl_word[`CTL_STRG_MSB:`CTL_STRG_LSB] = ctl_r.scan_trigger_select;
      ctl_word[`CTL_ON_BIT] = ctl_r.on;
      ctl_word[`CTL_IDLE_BIT] = ctl_r.idle_stop;
      sw_word = 32'h0000_0000;
      sw_word[`SW_LEVEL_BIT] = ctl_r.sw_level;
      stat_word = 32'h0000_0000;
      stat_word[7:0] = ctl_r.launch_count;
      stat_word[`STAT_RUN_BIT] = ctl_r.run;
   end

   // ***************************************************************
   // Control state and bus slave
   // ***************************************************************
   // A request is seen with waitrequest high, read data is loaded, and
   // waitrequest drops for one cycle; the write lands on the edge that ends it.
   assign accept = (i_read | i_write) & ~ctl_r.wait_req;

   always_comb begin
      ctl_nxt = ctl_r;
      ctl_nxt.sw_edge = 1'b0;
      // Idle stop only pauses launches; the registers stay reachable.
      ctl_nxt.run = ctl_r.on & ~(ctl_r.idle_stop & i_idle);
      ctl_nxt.scan_out = ctl_r.scan_input_select[`SCAN_HI_MSB:0];
      if (scan_hit) begin
         ctl_nxt.launch_count = ctl_r.launch_count + 8'h01;
      end
      if ((i_read | i_write) && ctl_r.wait_req) begin
         ctl_nxt.wait_req = 1'b0;
         unique case (i_address)
            `OFS_CONTROL_ONE: ctl_nxt.rdata = ctl_word;
            `OFS_TRIG_SEVEN: ctl_nxt.rdata = ctl_r.trig_seven;
            `OFS_SCAN_SELECT: ctl_nxt.rdata = ctl_r.scan_input_select;
            `OFS_SW_TRIGGER: ctl_nxt.rdata = sw_word;
            `OFS_STATUS: ctl_nxt.rdata = stat_word;
            default: ctl_nxt.rdata = 32'h0000_0000;
         endcase
      end else begin
         ctl_nxt.wait_req = 1'b1;
      end
      if (accept && i_write) begin
         unique case (i_address)
            `OFS_CONTROL_ONE: begin
               if (i_byteenable[2]) begin
                  ctl_nxt.scan_trigger_select =
                     i_writedata[`CTL_STRG_MSB:`CTL_STRG_LSB];
               end
               if (i_byteenable[1]) begin
                  ctl_nxt.on = i_writedata[`CTL_ON_BIT];
                  ctl_nxt.idle_stop = i_writedata[`CTL_IDLE_BIT];
               end
            end
            `OFS_TRIG_SEVEN: begin
               ctl_nxt.trig_seven = (ctl_r.trig_seven & ~bmask) |
                  (i_writedata & bmask & `MASK_TRIG_SEVEN);
            end
            `OFS_SCAN_SELECT: begin
               ctl_nxt.scan_input_select =
                  (ctl_r.scan_input_select & ~bmask) |
                  (i_writedata & bmask & `MASK_SCAN_SELECT);
            end
            `OFS_SW_TRIGGER: begin
               if (i_byteenable[0]) begin
                  ctl_nxt.sw_edge = i_writedata[`SW_EDGE_BIT];
                  ctl_nxt.sw_level = i_writedata[`SW_LEVEL_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_r <= '0;
         ctl_r.wait_req <= 1'b1;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign o_readdata = ctl_r.rdata;
   assign o_waitrequest = ctl_r.wait_req;
   assign o_scan_start = scan_hit;
   assign o_scan_inputs = ctl_r.scan_out;
   assign o_input_start = input_hit;
   assign o_adc_on = ctl_r.on;
   assign o_adc_run = ctl_r.run;
endmodule

// >>> trig_event_model.sv
/* Model of the on-chip event sources: timers, PWM and compare units.
   Assumes the bench asks for one event at a time, off the clock edge. */
`timescale 1ns/1ps
module trig_event_model (
   input wire logic i_mclk,       // System clock.
   input wire logic i_rst_n,      // Async reset, low.
   input wire logic i_fire,       // Request one event.
   input wire logic [4:0] i_code, // Trigger code of the source.
   output logic [31:0] o_src      // Bit n is the source of code n.
);
   // ********************************
   // Event pulses
   // ********************************
   // Events are registered and drop at once, as real units do.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_src <= 32'h00000000;
      end else begin
         o_src <= i_fire ? (32'h00000001 << i_code) : 32'h00000000;
      end
   end
endmodule

// >>> adc_scan_trigger_select_props.sv
/* Concurrent checks of the scan trigger selection block.
   Assumes binding to the top module, of whose ports it sees a part. */
`timescale 1ns/1ps
`include "adc_trig_map.svh"
module adc_scan_trigger_select_props (
   input wire logic i_mclk,               // System clock.
   input wire logic i_rst_n,              // Async reset, low.
   input wire logic [7:0] i_address,      // Bus address.
   input wire logic i_read,               // Bus read.
   input wire logic i_write,              // Bus write.
   input wire logic i_idle,               // Idle mode.
   input wire logic o_waitrequest,        // Bus wait.
   input wire logic o_scan_start,         // Launch pulse.
   input wire logic [21:0] o_scan_inputs, // Scanned inputs.
   input wire logic o_adc_on,             // Module enabled.
   input wire logic o_adc_run             // Module running.
);
   // ********************************
   // Properties
   // ********************************
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   logic wr_done;
   logic wr_scan;
   assign wr_done = i_write && !o_waitrequest;
   assign wr_scan = wr_done && i_address == `OFS_SCAN_SELECT;
   wait_one_a: assert property
      ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("wait state not one cycle");
   wait_short_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("wait low too long");
   wait_idle_a: assert property (!(i_read || i_write) |=> o_waitrequest)
      else $error("wait low without request");
   run_off_a: assert property (!o_adc_on |=> !o_adc_run)
      else $error("running while disabled");
   run_live_a: assert property (o_adc_on && !i_idle |=> o_adc_run)
      else $error("not running while enabled");
   start_on_a: assert property
      (o_scan_start |-> $past(o_adc_on) || $past(o_adc_on, 2))
      else $error("launch while disabled");
   scan_copy_a: assert property
      ($changed(o_scan_inputs) |-> $past(wr_scan) || $past(wr_scan, 2))
      else $error("scan inputs changed without write");
   on_write_a: assert property
      ($changed(o_adc_on) |->
       $past(wr_done && i_address == `OFS_CONTROL_ONE))
      else $error("enable changed without write");
endmodule
bind adc_scan_trigger_select adc_scan_trigger_select_props
   adc_scan_trigger_select_props_i (.i_mclk, .i_rst_n, .i_address,
   .i_read, .i_write, .i_idle, .o_waitrequest, .o_scan_start,
   .o_scan_inputs, .o_adc_on, .o_adc_run);

// >>> adc_scan_trigger_select_bench.sv
/* Self-checking bench of the scan trigger selection block.
   Assumes the event model and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "adc_trig_map.svh"
module adc_scan_trigger_select_bench;
   import adc_trig_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, idle = 1'b0;
   logic fire = 1'b0, wq, start, on, run;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h00000000, rdat, q, src;
   logic [21:0] scan_in;
   logic [3:0] in_start;
   trig_code_t code = 5'h00;
   int miscompares = 0, check_count = 0, launches = 0, cycles = 0;
   int in_cnt [4] = '{0, 0, 0, 0};
   always #2 mclk = ~mclk;
   adc_scan_trigger_select adc_scan_trigger_select_i (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_address(adr), .i_read(rd),
      .i_write(wr), .i_byteenable(4'hf), .i_writedata(wd),
      .o_readdata(q), .o_waitrequest(wq), .i_idle(idle),
      .i_scan_trig(src[3]), .i_ext_int0(src[4]), .i_timer_evt(src[7:5]),
      .i_pwm_tb(src[9:8]), .i_pwm_trig(src[15:10]),
      .i_oc_end(src[19:16]), .i_charge_trip(src[20]),
      .i_pwm_ilim(src[29:24]), .o_scan_start(start),
      .o_scan_inputs(scan_in), .o_input_start(in_start),
      .o_adc_on(on), .o_adc_run(run));
   trig_event_model trig_event_model_i (.i_mclk(mclk), .i_rst_n(rst_n),
      .i_fire(fire), .i_code(code), .o_src(src));
   // ********************************
   // Tasks
   // ********************************
   task automatic check(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // An idle edge follows each access so no request is driven twice.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge mclk);
      while (wq !== 1'b0) @(posedge mclk);
      rdat = q;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic pulse(input logic [4:0] c);
      code <= c;
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask
   function automatic logic valid(input int c);
      return c == 1 || (c >= 3 && c <= 20) || (c >= 24 && c <= 29);
   endfunction
   always @(posedge mclk) begin
      cycles++;
      if (start === 1'b1) launches++;
      for (int i = 0; i < 4; i++) if (in_start[i] === 1'b1) in_cnt[i]++;
      if (cycles == 5000) begin
         miscompares++;
         finish_test();
      end
   end
   // ********************************
   // Tests
   // ********************************
   initial begin
      int base;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      bus(0, `OFS_CONTROL_ONE, 0);
      check("control reset", 0, rdat);
      bus(1, 8'h40, 32'hffffffff);
      bus(0, 8'h40, 0);
      check("unmapped", 0, rdat);
      bus(1, `OFS_CONTROL_ONE, 32'hffffffff);
      bus(0, `OFS_CONTROL_ONE, 0);
      check("control mask", `MASK_CONTROL_ONE, rdat);
      for (int c = 0; c < 32; c++) begin
         bus(1, `OFS_CONTROL_ONE, c << 16);
         bus(1, `OFS_CONTROL_ONE, (c << 16) | 32'h00008000);
         base = launches;
         if (c == 1) bus(1, `OFS_SW_TRIGGER, 32'h00000001);
         if (c != 1 && c != 2) pulse(valid(c) ? c[4:0] : 5'h05);
         repeat (6) @(posedge mclk);
         if (c != 2) check($sformatf("code %0d", c), valid(c),
            launches - base);
      end
      bus(1, `OFS_CONTROL_ONE, 32'h00028000);
      base = launches;
      bus(1, `OFS_SW_TRIGGER, 32'h00000002);
      repeat (10) @(posedge mclk);
      bus(1, `OFS_SW_TRIGGER, 32'h00000000);
      repeat (4) @(posedge mclk);
      check("level repeats", 1, launches - base > 8);
      bus(0, `OFS_STATUS, 0);
      check("status", 32'h100 | (launches & 32'hff), rdat);
      bus(1, `OFS_CONTROL_ONE, 32'h00050000);
      base = launches;
      pulse(5'h05);
      check("disabled", 0, launches - base);
      check("enable", 0, on);
      bus(1, `OFS_CONTROL_ONE, 32'h0005a000);
      idle <= 1'b1;
      pulse(5'h05);
      check("idle stop", 0, launches - base);
      check("idle run", 0, run);
      bus(1, `OFS_CONTROL_ONE, 32'h00058000);
      pulse(5'h05);
      check("idle go", 1, launches - base);
      check("run", 1, run);
      idle <= 1'b0;
      bus(1, `OFS_TRIG_SEVEN, 32'hffffffff);
      bus(0, `OFS_TRIG_SEVEN, 0);
      check("input mask", `MASK_TRIG_SEVEN, rdat);
      bus(1, `OFS_TRIG_SEVEN, 32'h03000005);
      bus(1, `OFS_SCAN_SELECT, 32'h083fffff);
      repeat (2) @(posedge mclk);
      check("scan inputs", 22'h3fffff, scan_in);
      bus(1, `OFS_CONTROL_ONE, 32'h00068000);
      pulse(5'h05);
      check("input 24", 1, in_cnt[0]);
      pulse(5'h06);
      check("input 27", 1, in_cnt[3]);
      check("input 25", 0, in_cnt[1]);
      finish_test();
   end
endmodule
